// file: shared/period_timer_pkg.sv
// Purpose: Shared constants and types of the 8-bit period timer
// Assumes: 32-bit APB, registers one word each at index times four
// Notes:   Register indexes kept as printed, byte address derived
`default_nettype none
package period_timer_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;

    // Register indexes
    localparam logic [7:0] IDX_FLAGS   = 8'h0c;
    localparam logic [7:0] IDX_CLEAR   = 8'h0d;
    localparam logic [7:0] IDX_COUNT   = 8'h11;
    localparam logic [7:0] IDX_CONTROL = 8'h12;
    localparam logic [7:0] IDX_ENABLES = 8'h8c;
    localparam logic [7:0] IDX_PERIOD  = 8'h92;

    // Byte addresses
    localparam logic [ADDR_W-1:0] ADDR_FLAGS   = {2'b00, IDX_FLAGS, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CLEAR   = {2'b00, IDX_CLEAR, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_COUNT   = {2'b00, IDX_COUNT, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = {2'b00, IDX_CONTROL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_ENABLES = {2'b00, IDX_ENABLES, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PERIOD  = {2'b00, IDX_PERIOD, 2'b00};

    // Reset values
    localparam logic [7:0] RST_COUNT   = 8'h00;
    localparam logic [7:0] RST_PERIOD  = 8'hff;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_FLAGS   = 8'h00;
    localparam logic [7:0] RST_ENABLES = 8'h00;
    localparam logic [7:0] COUNT_ZERO  = 8'h00;

    // Flag and enable bit position of the period event
    localparam int PERIOD_FLAG_BIT = 1;

    // Instruction clock is the oscillator divided by four
    localparam int INSTR_DIVIDE = 4;

    // Prescaler terminal counts
    localparam int PRE_W = 4;
    localparam logic [PRE_W-1:0] PRE_LIMIT_1  = 4'h0;
    localparam logic [PRE_W-1:0] PRE_LIMIT_4  = 4'h3;
    localparam logic [PRE_W-1:0] PRE_LIMIT_16 = 4'hf;
    localparam int POST_W = 4;

    typedef enum logic [1:0] {
        PRESCALE_1  = 2'b00,
        PRESCALE_4  = 2'b01,
        PRESCALE_16 = 2'b10,
        PRESCALE_16B = 2'b11
    } prescale_type;

    typedef struct packed {
        logic              unused;
        logic [POST_W-1:0] postscale_select;
        logic              timer_run;
        prescale_type      prescale_select;
    } timer_control_type;

endpackage
`default_nettype wire

// file: hdl/instr_divider.sv
// Purpose: Instruction clock enable from the reference clock
// Assumes: DIVIDE of two or more
// Notes:   One-cycle pulse every DIVIDE reference cycles
`timescale 1ns/1ps
`default_nettype none
module instr_divider #(
    parameter int DIVIDE = 4
) (
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    output logic      tick_o
);
    localparam int W = $clog2(DIVIDE);
    localparam logic [W-1:0] LAST = W'(DIVIDE - 1);
    localparam logic [W-1:0] ONE  = W'(1);

    logic [W-1:0] phase_reg;
    logic [W-1:0] phase_next;

    assign tick_o     = (phase_reg == LAST);
    assign phase_next = tick_o ? '0 : phase_reg + ONE;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase_reg <= '0;
        end else begin
            phase_reg <= phase_next;
        end
    end
endmodule
`default_nettype wire

// file: hdl/scale_counter.sv
// Purpose: Modulo counter for prescaler and postscaler
// Assumes: limit_i stable between clears
// Notes:   wrap_o is combinational, high on the step that wraps
`timescale 1ns/1ps
`default_nettype none
module scale_counter #(
    parameter int WIDTH = 4
) (
    input  wire logic             ref_clk_i,
    input  wire logic             resetn_i,
    input  wire logic             clear_i,
    input  wire logic             step_i,
    input  wire logic [WIDTH-1:0] limit_i,
    output logic                  wrap_o,
    output logic      [WIDTH-1:0] count_o
);
    localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    assign wrap_o     = step_i && !clear_i && (count_reg == limit_i);
    assign count_next = (clear_i || wrap_o) ? '0 :
                        step_i ? count_reg + ONE : count_reg;
    assign count_o    = count_reg;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule
`default_nettype wire

// file: hdl/eight_bit_period_timer.sv
// Purpose: 8-bit period timer with prescaler, postscaler and APB registers
// Assumes: APB master keeps the protocol; one reference clock
// Notes:   Zero wait states; read data sampled in the setup cycle
`timescale 1ns/1ps
`default_nettype none
module eight_bit_period_timer
    import period_timer_pkg::*;
#(
    parameter int INSTR_DIV = period_timer_pkg::INSTR_DIVIDE
) (
    input  wire logic                                ref_clk_i,
    input  wire logic                                resetn_i,
    input  wire logic                                psel_i,
    input  wire logic                                penable_i,
    input  wire logic                                pwrite_i,
    input  wire logic [period_timer_pkg::ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]                         pwdata_i,
    output logic      [31:0]                         prdata_o,
    output logic                                     pready_o,
    output logic                                     pslverr_o,
    output logic                                     period_match_o,
    output logic      [period_timer_pkg::DATA_W-1:0] timer_count_o,
    output logic                                     irq_o
);
    import period_timer_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic              [DATA_W-1:0] count_reg;
    logic              [DATA_W-1:0] count_next;
    logic              [DATA_W-1:0] period_reg;
    timer_control_type              control_reg;
    logic              [DATA_W-1:0] flags_reg;
    logic              [DATA_W-1:0] flags_next;
    logic              [DATA_W-1:0] enables_reg;
    logic              [31:0]       prdata_reg;
    logic                           match_reg;

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    logic              setup_phase;
    logic              write_access;
    logic              wr_count;
    logic              wr_control;
    logic              wr_period;
    logic              wr_enables;
    logic              wr_clear;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rd_value;
    logic [DATA_W-1:0] control_rd;

    assign setup_phase  = psel_i && !penable_i;
    assign write_access = psel_i && penable_i && pwrite_i;
    assign wdata        = pwdata_i[DATA_W-1:0];
    assign wr_count     = write_access && (paddr_i == ADDR_COUNT);
    assign wr_control   = write_access && (paddr_i == ADDR_CONTROL);
    assign wr_period    = write_access && (paddr_i == ADDR_PERIOD);
    assign wr_enables   = write_access && (paddr_i == ADDR_ENABLES);
    assign wr_clear     = write_access && (paddr_i == ADDR_CLEAR);

    // Unimplemented top bit forced low on read
    assign control_rd   = {1'b0, control_reg[DATA_W-2:0]};

    assign rd_value = (paddr_i == ADDR_COUNT)   ? count_reg :
                      (paddr_i == ADDR_CONTROL) ? control_rd :
                      (paddr_i == ADDR_PERIOD)  ? period_reg :
                      (paddr_i == ADDR_FLAGS)   ? flags_reg :
                      (paddr_i == ADDR_ENABLES) ? enables_reg :
                      COUNT_ZERO;

    assign pready_o  = 1'b1;
    assign pslverr_o = 1'b0;
    assign prdata_o  = prdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Clocking chain

    logic             instr_tick;
    logic             scaler_clear;
    logic             pre_step;
    logic             pre_tick;
    logic [PRE_W-1:0] pre_limit;
    logic [PRE_W-1:0] pre_count;
    logic             period_hit;
    logic             match_event;
    logic             post_wrap;
    logic [POST_W-1:0] post_count;

    instr_divider #(
        .DIVIDE (INSTR_DIV)
    ) u_instr_divider (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .tick_o    (instr_tick)
    );

    // Either upper code gives divide by sixteen
    assign pre_limit = (control_reg.prescale_select == PRESCALE_1) ? PRE_LIMIT_1 :
                       (control_reg.prescale_select == PRESCALE_4) ? PRE_LIMIT_4 :
                       PRE_LIMIT_16;

    assign scaler_clear = wr_count || wr_control;
    assign pre_step     = instr_tick && control_reg.timer_run;

    scale_counter #(
        .WIDTH (PRE_W)
    ) u_prescaler (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .clear_i   (scaler_clear),
        .step_i    (pre_step),
        .limit_i   (pre_limit),
        .wrap_o    (pre_tick),
        .count_o   (pre_count)
    );

    assign period_hit  = (count_reg == period_reg);
    assign match_event = pre_tick && period_hit && !wr_count;

    scale_counter #(
        .WIDTH (POST_W)
    ) u_postscaler (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .clear_i   (scaler_clear),
        .step_i    (match_event),
        .limit_i   (control_reg.postscale_select),
        .wrap_o    (post_wrap),
        .count_o   (post_count)
    );

    ////////////////////////////////////////////////////////////////////////
    // Count and flags

    // Software write wins over an increment in the same cycle
    assign count_next = wr_count ? wdata :
                        !pre_tick ? count_reg :
                        period_hit ? COUNT_ZERO :
                        count_reg + 8'h01;

    // Set wins over a clear in the same cycle
    always_comb begin
        flags_next = flags_reg;
        if (wr_clear) begin
            flags_next = flags_reg & ~wdata;
        end
        if (post_wrap) begin
            flags_next[PERIOD_FLAG_BIT] = 1'b1;
        end
    end

    assign timer_count_o  = count_reg;
    assign period_match_o = match_reg;
    assign irq_o          = |(flags_reg & enables_reg);

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_reg <= RST_COUNT;
            match_reg <= 1'b0;
            flags_reg <= RST_FLAGS;
        end else begin
            count_reg <= count_next;
            match_reg <= match_event;
            flags_reg <= flags_next;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            period_reg  <= RST_PERIOD;
            control_reg <= timer_control_type'(RST_CONTROL);
            enables_reg <= RST_ENABLES;
        end else begin
            if (wr_period) begin
                period_reg <= wdata;
            end
            if (wr_control) begin
                control_reg <= timer_control_type'({1'b0, wdata[DATA_W-2:0]});
            end
            if (wr_enables) begin
                enables_reg <= wdata;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_phase && !pwrite_i) begin
            prdata_reg <= {24'h00_0000, rd_value};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    count_wrap_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        pre_tick && period_hit && !wr_count |=> count_reg == COUNT_ZERO)
        else $error("count did not return to zero after period match");

    count_incr_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        pre_tick && !period_hit && !wr_count |=> count_reg == $past(count_reg) + 8'h01)
        else $error("count did not advance by one");

    stop_hold_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !control_reg.timer_run && !wr_count |=> $stable(count_reg))
        else $error("count moved while timer stopped");

    ctrl_keep_count_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_control && !pre_tick |=> count_reg == $past(count_reg))
        else $error("control write changed count");

    scaler_clear_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        scaler_clear |=> pre_count == '0 && post_count == '0)
        else $error("scalers not cleared by register write");

    divide_one_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        control_reg.prescale_select == PRESCALE_1 && pre_step && !scaler_clear |-> pre_tick)
        else $error("divide by one did not step every instruction tick");

    divide_sixteen_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        pre_tick && control_reg.prescale_select[1] |-> pre_count == PRE_LIMIT_16)
        else $error("divide by sixteen wrapped early");

    divide_four_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        pre_tick && control_reg.prescale_select == PRESCALE_4 |-> pre_count == PRE_LIMIT_4)
        else $error("divide by four wrapped early");

    post_ratio_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        post_wrap |-> post_count == control_reg.postscale_select)
        else $error("postscaler wrapped at wrong ratio");

    flag_set_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        post_wrap |=> flags_reg[PERIOD_FLAG_BIT])
        else $error("postscaler output did not set flag");

    flag_sticky_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        flags_reg[PERIOD_FLAG_BIT] && !wr_clear |=> flags_reg[PERIOD_FLAG_BIT])
        else $error("flag dropped without a clear");

    irq_gate_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        flags_reg[PERIOD_FLAG_BIT] && enables_reg[PERIOD_FLAG_BIT] |-> irq_o)
        else $error("enabled flag gave no interrupt");

    match_out_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        match_event |=> period_match_o ##1 !period_match_o || $past(match_event, 1))
        else $error("match pulse not offered");

    period_write_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_period |=> period_reg == $past(wdata))
        else $error("period write not stored");

    ctrl_bit7_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        setup_phase && !pwrite_i && paddr_i == ADDR_CONTROL |=> prdata_o[7] == 1'b0)
        else $error("unimplemented control bit read as one");

    count_load_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_count |=> count_reg == $past(wdata))
        else $error("count write not stored");

    flag_clear_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_clear && wdata[PERIOD_FLAG_BIT] && !post_wrap |=> !flags_reg[PERIOD_FLAG_BIT])
        else $error("flag clear had no effect");

    match_source_a: assert property (
        @(posedge ref_clk_i) disable iff (!resetn_i)
        period_match_o |-> $past(pre_tick) && $past(period_hit))
        else $error("match pulse without a period match");

endmodule
`default_nettype wire

// file: test/testbench.sv
// Purpose: Self-checking bench of the 8-bit period timer
// Assumes: Zero wait state APB slave; instruction divider shortened to 2
// Notes:   Registers, prescaler, postscaler, interrupt and resets
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("Error %s expected %0h seen %0h", nm, exp, got); \
    end \
end
module testbench;
    import period_timer_pkg::*;
    localparam int DIV = 2;
    logic              ref_clk_i;
    logic              resetn_i;
    logic              psel_i;
    logic              penable_i;
    logic              pwrite_i;
    logic [ADDR_W-1:0] paddr_i;
    logic [31:0]       pwdata_i;
    logic [31:0]       prdata_o;
    logic              pready_o;
    logic              pslverr_o;
    logic              period_match_o;
    logic [DATA_W-1:0] timer_count_o;
    logic              irq_o;
    int                error_cnt = 0;
    int                cmp_count = 0;
    int                gap;
    logic [7:0]        mx;
    int                n;

    eight_bit_period_timer #(.INSTR_DIV(DIV)) u_dut (
        .ref_clk_i      (ref_clk_i),
        .resetn_i       (resetn_i),
        .psel_i         (psel_i),
        .penable_i      (penable_i),
        .pwrite_i       (pwrite_i),
        .paddr_i        (paddr_i),
        .pwdata_i       (pwdata_i),
        .prdata_o       (prdata_o),
        .pready_o       (pready_o),
        .pslverr_o      (pslverr_o),
        .period_match_o (period_match_o),
        .timer_count_o  (timer_count_o),
        .irq_o          (irq_o)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic results;
        $display("Compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        error_cnt++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////
    // One APB transfer, held until pready is seen high
    task automatic apb(input logic is_wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int k;
        k = 0;
        @(posedge ref_clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= is_wr;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 100);
        q = prdata_o;
        `CHECK("slave error", 1'b0, pslverr_o)
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        if (k >= 100) error_cnt++;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        `CHECK(nm, e, q)
    endtask

    // Cycles between two match pulses and highest count seen between them
    task automatic match_gap(output int g, output logic [7:0] m);
        int k;
        k = 0;
        g = 0;
        m = 8'h00;
        do begin
            @(posedge ref_clk_i);
            #1;
            k++;
        end while (period_match_o !== 1'b1 && k < 2000);
        do begin
            if (timer_count_o > m) m = timer_count_o;
            @(posedge ref_clk_i);
            #1;
            g++;
        end while (period_match_o !== 1'b1 && g < 2000);
    endtask

    // Matches needed to raise the enabled interrupt
    task automatic post_run(input int ratio);
        int m;
        m = 0;
        n = 0;
        wr(ADDR_CONTROL, 32'h0);
        wr(ADDR_CLEAR, 32'h2);
        wr(ADDR_CONTROL, {24'h0, 1'b0, 4'(ratio - 1), 1'b1, 2'b00});
        while (irq_o !== 1'b1 && n < 3000) begin
            @(posedge ref_clk_i);
            #1;
            n++;
            if (period_match_o === 1'b1) m++;
        end
        `CHECK("postscaled matches", ratio, m)
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        resetn_i  = 1'b0;
        psel_i    = 1'b0;
        penable_i = 1'b0;
        pwrite_i  = 1'b0;
        paddr_i   = '0;
        pwdata_i  = 32'h0;
        repeat (12) @(posedge ref_clk_i);
        resetn_i <= 1'b1;

        // Reset values and access kinds
        rd_chk(ADDR_COUNT, 32'h0, "count reset");
        rd_chk(ADDR_PERIOD, 32'hff, "period reset");
        rd_chk(ADDR_CONTROL, 32'h0, "control reset");
        rd_chk(ADDR_FLAGS, 32'h0, "flags reset");
        rd_chk(ADDR_ENABLES, 32'h0, "enables reset");
        rd_chk(12'h3fc, 32'h0, "unmapped read");
        wr(ADDR_PERIOD, 32'h5a);
        rd_chk(ADDR_PERIOD, 32'h5a, "period rw");
        wr(ADDR_CONTROL, 32'hff);
        rd_chk(ADDR_CONTROL, 32'h7f, "control bit7");

        // Every prescale code, count wraps at period
        wr(ADDR_CONTROL, 32'h0);
        wr(ADDR_PERIOD, 32'h3);
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_CONTROL, {29'h0, 1'b1, 2'(c)});
            match_gap(gap, mx);
            `CHECK("match gap", 4 * DIV * (c == 0 ? 1 : (c == 1 ? 4 : 16)), gap)
            `CHECK("count max", 8'h03, mx)
        end

        // Period zero matches on every increment
        wr(ADDR_PERIOD, 32'h0);
        wr(ADDR_CONTROL, 32'h4);
        match_gap(gap, mx);
        `CHECK("zero period gap", DIV, gap)
        `CHECK("zero period count", 8'h00, mx)

        // Count write clears a part-way prescaler
        wr(ADDR_PERIOD, 32'hff);
        wr(ADDR_CONTROL, 32'h6);
        repeat (7) @(posedge ref_clk_i);
        wr(ADDR_COUNT, 32'h10);
        n = 0;
        do begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end while (timer_count_o === 8'h10 && n < 200);
        `CHECK("prescale restart", 1'b1, (n >= 15 * DIV + 1 && n <= 16 * DIV))
        `CHECK("count step", 8'h11, timer_count_o)

        // Control write keeps the count, stopped timer holds
        wr(ADDR_CONTROL, 32'h0);
        wr(ADDR_COUNT, 32'h5);
        wr(ADDR_CONTROL, 32'h0);
        rd_chk(ADDR_COUNT, 32'h5, "count kept");
        repeat (40) @(posedge ref_clk_i);
        `CHECK("stopped count", 8'h05, timer_count_o)

        // Postscaler ratios and the interrupt
        wr(ADDR_PERIOD, 32'h1);
        wr(ADDR_ENABLES, 32'h2);
        post_run(1);
        post_run(3);
        post_run(16);
        `CHECK("irq raised", 1'b1, irq_o)
        wr(ADDR_CONTROL, 32'h0);
        wr(ADDR_FLAGS, 32'h0);
        rd_chk(ADDR_FLAGS, 32'h2, "flag sticky");
        wr(ADDR_ENABLES, 32'h0);
        @(posedge ref_clk_i);
        #1;
        `CHECK("irq masked", 1'b0, irq_o)
        wr(ADDR_CLEAR, 32'h2);
        rd_chk(ADDR_FLAGS, 32'h0, "flag cleared");

        // Second reset mid-run
        wr(ADDR_CONTROL, 32'h4);
        repeat (9) @(posedge ref_clk_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        rd_chk(ADDR_PERIOD, 32'hff, "period rereset");
        rd_chk(ADDR_CONTROL, 32'h0, "control rereset");
        `CHECK("count rereset", 8'h00, timer_count_o)
        results();
    end
endmodule
`default_nettype wire
